// ===== bench/spc_sleep_power_control_tb.sv
// self-checking bench for the sleep and power control block
// assumes the block's axi4-lite port, one 200 mhz clock and a shortened wake stretch
module spc_sleep_power_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import spc_pkg::*;

    // ==========================================================
    // stimulus and observation signals
    localparam int WAKE_CYC = 20;  // short stretch keeps the run brief
    logic        aclk;
    logic        aresetn;
    logic [3:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic        bvalid;
    logic        bready;
    logic        rready;
    logic        clk_en;
    logic [3:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic        rvalid;
    logic        sleep_instr;
    logic        wake_event;
    logic        fuse;
    logic        wdt_en;
    logic [11:0] dig_pins;
    logic        sleeping;
    logic        cpu_halt;
    spc_clk_t    clk_out;
    spc_ana_t    ana_out;
    int          errors;
    int          checked;
    logic [7:0]  rd;
    int          n;

    spc_sleep_power_control #(.BOD_WAKE_CYC(WAKE_CYC), .HAS_BOD_SW(1'b1)) uut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_instr(sleep_instr), .wake_event(wake_event), .brownout_level_fuse(fuse),
        .wdt_enabled(wdt_en), .wake_pin_mask(12'ha5c), .clk_out(clk_out),
        .ana_out(ana_out), .dig_in_en_pins(dig_pins), .sleeping(sleeping),
        .cpu_halt(cpu_halt)
    );

    // ==========================================================
    // clock
    always #2.5 aclk = ~aclk;

    // ==========================================================
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask

    // bready rises with the request and stays high, so the response is taken when seen
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        int   i;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (aw_ok && w_ok && bvalid) break;
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (i == 64) begin
            errors++;
            test_done();
        end
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [7:0] d);
        logic ar_ok;
        int   i;
        ar_ok = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (ar_ok && rvalid) break;
            if (!ar_ok && arready) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
        end
        d = rdata[7:0];
        if (i == 64) begin
            errors++;
            test_done();
        end
    endtask

    // one-cycle sleep instruction, then let the outputs settle
    task automatic sleep_now;
        sleep_instr <= 1'b1;
        tick(1);
        sleep_instr <= 1'b0;
        tick(2);
    endtask

    // returns the cycles that the cpu stays halted after the wake event
    task automatic wake_up(output int k);
        wake_event <= 1'b1;
        tick(1);
        wake_event <= 1'b0;
        for (k = 0; k < 200 && cpu_halt !== 1'b0; k++) tick(1);
        if (k == 200) begin
            errors++;
            test_done();
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_gate;
        axi_rd(SPC_OFF_GATE, rd);
        chk(rd, 8'h00);
        axi_wr(SPC_OFF_CFG, 8'h03);
        axi_wr(SPC_OFF_GATE, 8'hff);
        axi_rd(SPC_OFF_GATE, rd);
        chk(rd, 8'h0f);
        chk(clk_out[3:0], 4'h0);
        chk(ana_out.cmp_en, 1'b0);
        axi_wr(SPC_OFF_GATE, 8'h05);
        tick(2);
        chk({clk_out.t16_clk_en, clk_out.t8_clk_en}, 2'b10);
        chk({clk_out.ser_clk_en, clk_out.cnv_clk_en}, 2'b10);
        axi_wr(SPC_OFF_GATE, 8'h00);
        tick(2);
        chk(clk_out[3:0], 4'hf);
    endtask

    // every mode code, converter and comparator left on, fuse detector on
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wdt_en <= m[0];
            axi_wr(SPC_OFF_CTRL, {2'b00, 1'b1, m[1:0], 3'b000});
            sleep_now();
            chk(sleeping, 1'b1);
            chk(clk_out[7:4], {1'b0, m == 0, m < 2, m != 2});
            chk(dig_pins, m[1] ? 12'ha5c : 12'hfff);
            chk(ana_out.cmp_en, !m[1]);
            chk({ana_out.cnv_en, ana_out.wdt_run}, {1'b1, m[0]});
            chk(ana_out.bod_en, 1'b1);
            wake_up(n);
            chk(sleeping, 1'b0);
        end
    endtask

    // sleep instruction ignored while sleep enable is clear
    task automatic t_no_enable;
        axi_wr(SPC_OFF_CTRL, 8'h10);
        sleep_now();
        chk({sleeping, clk_out.cpu_clk_en}, 2'b01);
    endtask

    // writes that skip or stretch the unlock step leave the bit clear
    task automatic t_locked;
        axi_wr(SPC_OFF_CTRL, 8'h80);
        axi_rd(SPC_OFF_CTRL, rd);
        chk(rd[7], 1'b0);
        axi_wr(SPC_OFF_CTRL, 8'h84);
        tick(6);
        axi_wr(SPC_OFF_CTRL, 8'h80);
        axi_rd(SPC_OFF_CTRL, rd);
        chk(rd[7], 1'b0);
    endtask

    // timed sequence, sleep in the first cycle of the active window
    task automatic t_brownout_sleep_disable(input logic [1:0] m);
        axi_wr(SPC_OFF_CTRL, {3'b101, m, 3'b100});
        axi_wr(SPC_OFF_CTRL, {3'b101, m, 3'b000}); // second step inside the window
        tick(2);
        sleep_now();
        chk(sleeping, 1'b1);
        chk(ana_out.bod_en, !m[1]);
        wake_up(n);
        chk(n >= WAKE_CYC, m[1]);
        tick(2);
        chk(ana_out.bod_en, 1'b1);
        axi_rd(SPC_OFF_CTRL, rd);
        chk(rd, {3'b001, m, 3'b000});
    endtask

    // reference demand table: fuse, config, expected reference enable
    task automatic t_vref;
        logic [4:0] tbl [6] = '{5'b0_000_0, 5'b0_001_1, 5'b0_110_1,
                                5'b0_010_0, 5'b0_100_0, 5'b1_000_1};
        axi_wr(SPC_OFF_CTRL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            fuse <= tbl[i][4];
            axi_wr(SPC_OFF_CFG, {5'h00, tbl[i][3:1]});
            tick(2);
            chk(ana_out.vref_en, tbl[i][0]);
        end
        axi_wr(SPC_OFF_CFG, 8'h01);
        tick(2);
        chk(ana_out.cnv_extended, 1'b1);
    endtask

    // a frozen block ignores a sleep request; a mid-run reset restores the defaults
    task automatic t_freeze_reset;
        axi_wr(SPC_OFF_CTRL, 8'h20);
        axi_wr(SPC_OFF_GATE, 8'h0f);
        clk_en <= 1'b0;
        sleep_now();
        chk(sleeping, 1'b0);
        clk_en <= 1'b1;
        tick(1);
        chk(clk_out[3:0], 4'h0);
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        tick(1);
        axi_rd(SPC_OFF_CTRL, rd);
        chk(rd, SPC_CTRL_RST);
        axi_rd(SPC_OFF_GATE, rd);
        chk(rd, SPC_GATE_RST);
        chk(clk_out[3:0], 4'hf);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        awaddr = 4'h0;
        awvalid = 1'b0;
        wdata = 32'h0;
        wvalid = 1'b0;
        araddr = 4'h0;
        arvalid = 1'b0;
        bready = 1'b0;
        rready = 1'b0;
        clk_en = 1'b1;
        sleep_instr = 1'b0;
        wake_event = 1'b0;
        fuse = 1'b1;
        wdt_en = 1'b1;
        errors = 0;
        checked = 0;
        tick(8);
        aresetn <= 1'b1;
        tick(1);
        axi_rd(SPC_OFF_CTRL, rd);
        chk(rd, SPC_CTRL_RST);
        t_gate();
        t_modes();
        t_no_enable();
        t_locked();
        t_brownout_sleep_disable(2'b10);
        t_brownout_sleep_disable(2'b11); // standby, bench assumes a crystal clock source
        t_brownout_sleep_disable(2'b00);
        t_vref();
        t_freeze_reset();
        test_done();
    end
endmodule // spc_sleep_power_control_tb

// ===== rtl/spc_pkg.sv
// package for the sleep and power control block
// assumes a single 200 mhz clock domain and an axi4-lite register port
package spc_pkg;

    // ==========================================================
    // register map
    localparam logic [3:0] SPC_OFF_CTRL = 4'h0;  // sleep_power_control_reg
    localparam logic [3:0] SPC_OFF_GATE = 4'h4;  // peripheral_clock_gate_reg
    localparam logic [3:0] SPC_OFF_CFG  = 4'h8;  // analog helper enables
    localparam logic [3:0] SPC_OFF_STAT = 4'hc;  // live status

    // ==========================================================
    // control register fields
    localparam int SPC_BIT_BROWNOUT_SLEEP_DISABLE  = 7;
    localparam int SPC_BIT_SE    = 5;
    localparam int SPC_BIT_SM_LO = 3;
    localparam int SPC_BIT_BROWNOUT_SLEEP_DISABLE_UNLOCK = 2;
    localparam logic [7:0] SPC_CTRL_RST = 8'h00;

    // gate register fields
    localparam int SPC_BIT_GT16  = 3;
    localparam int SPC_BIT_GT8   = 2;
    localparam int SPC_BIT_GSER  = 1;
    localparam int SPC_BIT_GCNV  = 0;
    localparam logic [7:0] SPC_GATE_RST  = 8'h00;
    localparam logic [7:0] SPC_GATE_MASK = 8'h0f;

    // config register fields
    localparam int SPC_BIT_CNV_EN = 0;
    localparam int SPC_BIT_CMP_EN = 1;
    localparam int SPC_BIT_CMP_BG = 2;
    localparam logic [7:0] SPC_CFG_RST = 8'h00;

    // ==========================================================
    // timing
    localparam int SPC_CLK_MHZ      = 200;
    localparam int SPC_UNLOCK_CYC   = 4;  // window after the unlock write
    localparam int SPC_BROWNOUT_SLEEP_DISABLE_DLY_CYC = 3;  // delay until sleep-disable acts
    localparam int SPC_BROWNOUT_SLEEP_DISABLE_ACT_CYC = 3;  // active time before auto clear
    localparam int SPC_BOD_WAKE_US  = 60;
    localparam int SPC_BOD_WAKE_CYC = SPC_BOD_WAKE_US * SPC_CLK_MHZ;

    typedef enum logic [1:0] {
        SPC_SM_IDLE, SPC_SM_NOISE, SPC_SM_PDOWN, SPC_SM_STBY
    } spc_mode_t;

    typedef enum {SPC_ST_RUN, SPC_ST_SLEEP, SPC_ST_WAKE} spc_state_t;

    // clock request and enable bundle toward the power domain
    typedef struct packed {
        logic cpu_clk_en;
        logic io_clock_en;
        logic converter_clock_en;
        logic osc_en;
        logic t16_clk_en;
        logic t8_clk_en;
        logic ser_clk_en;
        logic cnv_clk_en;
    } spc_clk_t;

    // analog helper enables
    typedef struct packed {
        logic bod_en;
        logic cmp_en;
        logic cnv_en;
        logic vref_en;
        logic wdt_run;
        logic dig_in_en;
        logic cnv_extended;
    } spc_ana_t;

endpackage : spc_pkg

// ===== rtl/spc_sleep_power_control.sv
// sleep mode, brown-out sleep-disable and peripheral clock gating
// assumes one clock, synchronous inputs and an axi4-lite master on the register port
//
// How it works
// - an enabled converter stays enabled in every sleep mode
// - after converter off then on, next conversion is flagged extended
// - comparator forced off in power-down and standby
// - comparator using internal reference keeps reference on while comparator enabled
// - fuse-enabled brown-out stays on in sleep unless software disabled
// - reference on only when brown-out, comparator or converter needs it
// - enabled watchdog keeps running in every sleep mode
// - digital inputs off when io and converter clocks stop, wake pins kept
// - sleep-disable acts three cycles after set, clears three cycles later
// - brown-out off only if sleep starts while sleep-disable active
// - unlock bit 2 gates writes of sleep-disable bit 7
// - without software disable both bits read zero
// - sleep entered on sleep instruction only when bit 5 holds one
// - mode field bits 4:3 pick idle, noise, power-down, standby
// - gate register bits 7:4 read zero
// - gate bit 3 freezes the 16-bit timer, clearing resumes it
// - gate bit 2 freezes the 8-bit timer, clearing resumes it
// - gate bit 1 stops serial interface clock
// - gate bit 0 shuts converter and makes comparator unusable
// - sleep-disable turns detector off only in power-down and standby
// - after a brown-out-off sleep, detector back on, wake stretched 60 us
// - gated peripheral frozen, its state held while its clock stops
module spc_sleep_power_control #(
    parameter int          BOD_WAKE_CYC = spc_pkg::SPC_BOD_WAKE_CYC,
    parameter bit          HAS_BOD_SW   = 1'b1
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              sleep_instr,
    input  wire logic              wake_event,
    input  wire logic              brownout_level_fuse,
    input  wire logic              wdt_enabled,
    input  wire logic [11:0]       wake_pin_mask,
    output spc_pkg::spc_clk_t      clk_out,
    output spc_pkg::spc_ana_t      ana_out,
    output logic [11:0]            dig_in_en_pins,
    output logic                   sleeping,
    output logic                   cpu_halt
);
    import spc_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  gate;
        logic [7:0]  cfg;
        logic [2:0]  unlock_cnt;
        logic [2:0]  brownout_sleep_disable_cnt;
        logic        brownout_sleep_disable_act;
        logic        bod_off;
        logic        cnv_was_off;
        logic [31:0] wake_cnt;
        spc_state_t  st;
        logic        aw_got;
        logic [3:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
        spc_clk_t    clk;
        spc_ana_t    ana;
        logic [11:0] dig;
    } spc_state_s_t;

    spc_state_s_t st_ff;
    spc_state_s_t nxt_st;

    // read mux, also used for the status word
    function automatic logic [31:0] rd_word(input logic [3:0] a, input spc_state_s_t s);
        logic [7:0] c;
        c = s.ctrl;
        if (!HAS_BOD_SW) begin
            c[SPC_BIT_BROWNOUT_SLEEP_DISABLE]  = 1'b0;
            c[SPC_BIT_BROWNOUT_SLEEP_DISABLE_UNLOCK] = 1'b0;
        end
        case (a)
            SPC_OFF_CTRL: rd_word = {24'h000000, c};
            SPC_OFF_GATE: rd_word = {24'h000000, s.gate & SPC_GATE_MASK};
            SPC_OFF_CFG:  rd_word = {24'h000000, s.cfg};
            SPC_OFF_STAT: rd_word = {24'h000000, 1'b0, s.ana.vref_en, s.ana.bod_en,
                                     s.brownout_sleep_disable_act, s.bod_off, s.ana.cnv_extended,
                                     s.st == SPC_ST_SLEEP, s.st == SPC_ST_WAKE};
            default:      rd_word = 32'h00000000;
        endcase
    endfunction

    logic       do_wr;
    logic       brownout_sleep_disable_live;
    logic [1:0] mode;
    logic       deep;
    logic       io_stop;
    logic       cnv_stop;

    always_comb begin
        nxt_st = st_ff;
        do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        mode = st_ff.ctrl[SPC_BIT_SM_LO +: 2];
        deep = st_ff.st == SPC_ST_SLEEP && mode[1];
        brownout_sleep_disable_live = st_ff.brownout_sleep_disable_act;

        // axi handshakes: each channel taken once, response after both
        if (s_axi_awvalid && !st_ff.aw_got) begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got) begin
            nxt_st.w_got  = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd_word(s_axi_araddr, st_ff);
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // sleep-disable timing: unlock window then delayed active pulse
        if (st_ff.unlock_cnt != 3'h0) begin
            nxt_st.unlock_cnt = st_ff.unlock_cnt - 3'h1;
        end
        if (st_ff.brownout_sleep_disable_cnt != 3'h0) begin
            nxt_st.brownout_sleep_disable_cnt = st_ff.brownout_sleep_disable_cnt - 3'h1;
            if (st_ff.brownout_sleep_disable_cnt == 3'(SPC_BROWNOUT_SLEEP_DISABLE_ACT_CYC + 1)) begin
                nxt_st.brownout_sleep_disable_act = 1'b1;
            end
            if (st_ff.brownout_sleep_disable_cnt == 3'h1) begin
                nxt_st.brownout_sleep_disable_act = 1'b0;
                nxt_st.ctrl[SPC_BIT_BROWNOUT_SLEEP_DISABLE] = 1'b0;           // auto clear
            end
        end

        // register writes, low byte lane only carries data
        if (do_wr) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            if (st_ff.w_strb[0]) begin
                case (st_ff.aw_addr)
                    SPC_OFF_CTRL: begin
                        nxt_st.ctrl[SPC_BIT_SE] = st_ff.w_data[SPC_BIT_SE];
                        nxt_st.ctrl[SPC_BIT_SM_LO +: 2] = st_ff.w_data[SPC_BIT_SM_LO +: 2];
                        if (HAS_BOD_SW) begin
                            nxt_st.ctrl[SPC_BIT_BROWNOUT_SLEEP_DISABLE_UNLOCK] = st_ff.w_data[SPC_BIT_BROWNOUT_SLEEP_DISABLE_UNLOCK];
                            if (st_ff.w_data[SPC_BIT_BROWNOUT_SLEEP_DISABLE] && st_ff.w_data[SPC_BIT_BROWNOUT_SLEEP_DISABLE_UNLOCK]) begin
                                nxt_st.unlock_cnt = 3'(SPC_UNLOCK_CYC);
                            end else if (st_ff.w_data[SPC_BIT_BROWNOUT_SLEEP_DISABLE] &&
                                         st_ff.unlock_cnt != 3'h0) begin
                                // second step inside the window arms the bit
                                nxt_st.ctrl[SPC_BIT_BROWNOUT_SLEEP_DISABLE] = 1'b1;
                                nxt_st.unlock_cnt = 3'h0;
                                nxt_st.brownout_sleep_disable_cnt = 3'(SPC_BROWNOUT_SLEEP_DISABLE_DLY_CYC + SPC_BROWNOUT_SLEEP_DISABLE_ACT_CYC);
                            end
                        end
                    end
                    SPC_OFF_GATE: nxt_st.gate = st_ff.w_data[7:0] & SPC_GATE_MASK;
                    SPC_OFF_CFG:  nxt_st.cfg  = st_ff.w_data[7:0];
                    default: ;
                endcase
            end
        end
        if (st_ff.cfg[SPC_BIT_CNV_EN] == 1'b0) begin
            nxt_st.cnv_was_off = 1'b1;
        end

        // sleep sequencer
        case (st_ff.st)
            SPC_ST_RUN: begin
                if (sleep_instr && st_ff.ctrl[SPC_BIT_SE]) begin
                    nxt_st.st = SPC_ST_SLEEP;
                    // detector off only if sleep-disable active and deep mode
                    nxt_st.bod_off = brownout_sleep_disable_live && mode[1];
                end
            end
            SPC_ST_SLEEP: begin
                if (wake_event) begin
                    nxt_st.bod_off = 1'b0;                  // detector back on
                    if (st_ff.bod_off) begin
                        nxt_st.st = SPC_ST_WAKE;
                        nxt_st.wake_cnt = 32'(BOD_WAKE_CYC);
                    end else begin
                        nxt_st.st = SPC_ST_RUN;
                    end
                end
            end
            SPC_ST_WAKE: begin
                nxt_st.wake_cnt = st_ff.wake_cnt - 32'h1;
                if (st_ff.wake_cnt <= 32'h1) begin
                    nxt_st.st = SPC_ST_RUN;
                end
            end
            default: nxt_st.st = SPC_ST_RUN;
        endcase

        // clock outputs from the settled state
        io_stop  = st_ff.st != SPC_ST_RUN && mode != SPC_SM_IDLE;
        cnv_stop = st_ff.st != SPC_ST_RUN && mode[1];
        nxt_st.clk.cpu_clk_en         = st_ff.st == SPC_ST_RUN;
        nxt_st.clk.io_clock_en        = !io_stop;
        nxt_st.clk.converter_clock_en = !cnv_stop;
        nxt_st.clk.osc_en             = !(st_ff.st == SPC_ST_SLEEP && mode == SPC_SM_PDOWN);
        // gated peripherals hold state since their clock simply stops
        nxt_st.clk.t16_clk_en = !io_stop && !st_ff.gate[SPC_BIT_GT16];
        nxt_st.clk.t8_clk_en  = !io_stop && !st_ff.gate[SPC_BIT_GT8];
        nxt_st.clk.ser_clk_en = !io_stop && !st_ff.gate[SPC_BIT_GSER];
        nxt_st.clk.cnv_clk_en = !cnv_stop && !st_ff.gate[SPC_BIT_GCNV];

        // analog helpers
        nxt_st.ana.cnv_en = st_ff.cfg[SPC_BIT_CNV_EN] && !st_ff.gate[SPC_BIT_GCNV];
        nxt_st.ana.cmp_en = st_ff.cfg[SPC_BIT_CMP_EN] && !deep
                            && !st_ff.gate[SPC_BIT_GCNV];
        nxt_st.ana.bod_en = brownout_level_fuse && !st_ff.bod_off;
        // reference follows its three users comparator path
        nxt_st.ana.vref_en = nxt_st.ana.bod_en || nxt_st.ana.cnv_en ||
                             (nxt_st.ana.cmp_en && st_ff.cfg[SPC_BIT_CMP_BG]);
        nxt_st.ana.wdt_run = wdt_enabled;
        nxt_st.ana.dig_in_en = !(io_stop && cnv_stop);
        nxt_st.dig = nxt_st.ana.dig_in_en ? 12'hfff : wake_pin_mask;
        // first enable after an off period marks an extended conversion
        if (st_ff.cfg[SPC_BIT_CNV_EN] && st_ff.cnv_was_off) begin
            nxt_st.ana.cnv_extended = 1'b1;
            nxt_st.cnv_was_off = 1'b0;
        end else if (!st_ff.cfg[SPC_BIT_CNV_EN]) begin
            nxt_st.ana.cnv_extended = 1'b0;
        end
    end

    // ==========================================================
    // single state register with clock enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '{ctrl: SPC_CTRL_RST, gate: SPC_GATE_RST, cfg: SPC_CFG_RST,
                       st: SPC_ST_RUN, cnv_was_off: 1'b1,
                       clk: '{default: 1'b1}, dig: 12'hfff,
                       ana: '{wdt_run: 1'b0, default: 1'b0}, default: '0};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready  = !st_ff.aw_got && clk_en;   // a frozen slave must not look ready
    assign s_axi_wready   = !st_ff.w_got && clk_en;
    assign s_axi_bvalid   = st_ff.bvalid;
    assign s_axi_bresp    = 2'h0;
    assign s_axi_arready  = !st_ff.rvalid && clk_en;
    assign s_axi_rvalid   = st_ff.rvalid;
    assign s_axi_rdata    = st_ff.rdata;
    assign s_axi_rresp    = 2'h0;
    assign clk_out        = st_ff.clk;
    assign ana_out        = st_ff.ana;
    assign dig_in_en_pins = st_ff.dig;
    assign sleeping       = st_ff.st == SPC_ST_SLEEP;
    assign cpu_halt       = st_ff.st != SPC_ST_RUN;

    // ==========================================================
    // checks
    sequence arm_seq;
        $rose(st_ff.ctrl[SPC_BIT_BROWNOUT_SLEEP_DISABLE]);
    endsequence

    property brownout_sleep_disable_timing_p;
        @(posedge aclk) disable iff (!aresetn || !clk_en)
        arm_seq |-> !st_ff.brownout_sleep_disable_act ##3 st_ff.brownout_sleep_disable_act ##3 !st_ff.ctrl[SPC_BIT_BROWNOUT_SLEEP_DISABLE];
    endproperty
    brownout_sleep_disable_timing_a: assert property (brownout_sleep_disable_timing_p)
        else $error("sleep-disable timing wrong");

    sleep_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sleeping) |-> $past(st_ff.ctrl[SPC_BIT_SE]))
        else $error("sleep without enable");

    bod_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_ff.bod_off |-> mode[1])
        else $error("detector off outside deep mode");

    gate_rd_a: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == SPC_OFF_GATE) |=> ~|s_axi_rdata[7:4])
        else $error("reserved gate bits read back set");

    vref_a: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        ana_out.vref_en == (ana_out.bod_en || ana_out.cnv_en ||
                            (ana_out.cmp_en && ana_out.vref_en)))
        else $error("reference enable wrong");

    cmp_deep_a: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        deep |=> !ana_out.cmp_en)
        else $error("comparator on in deep sleep");

    wake_hold_a: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        (st_ff.st == SPC_ST_SLEEP && st_ff.bod_off && wake_event) |=> cpu_halt [*2])
        else $error("wake not stretched");

    t16_gate_a: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en)
        st_ff.gate[SPC_BIT_GT16] |=> !clk_out.t16_clk_en)
        else $error("timer clock not gated");

endmodule // spc_sleep_power_control
